// ==== core/mcs_core_sequencer.v ====
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "mcs_defs.vh"
module mcs_core_sequencer (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  output reg  [11:0] pm_addr,
  output reg         pm_rd,
  input  wire [15:0] pm_data,
  input  wire [5:0]  irq_req,
  output reg         irq_ack,
  output reg  [2:0]  irq_ack_id,
  output reg  [3:0]  instruction_phases,
  output reg  [11:0] table_addr
);

  function [11:0] mcs_alu;
    input [3:0] fn;
    input [7:0] a;
    input [7:0] b;
    input [3:0] fl;
    reg   [8:0] s;
    reg   [4:0] h;
    reg   [7:0] bb;
    reg   [7:0] adj;
    reg   [7:0] r;
    reg         ci;
    reg         c;
    reg         ac;
    reg         ov;
    begin
      s   = 9'h000;
      h   = 5'h00;
      adj = 8'h00;
      bb  = fn[1] ? ~b : b;
      ci  = fn[0] ? fl[`MCS_FL_C] : fn[1];
      r   = b;
      c   = fl[`MCS_FL_C];
      ac  = fl[`MCS_FL_AC];
      ov  = fl[`MCS_FL_OV];
      case (fn)
        `MCS_FN_ADD, `MCS_FN_ADC, `MCS_FN_SUB, `MCS_FN_SBC: begin
          // carry is the inverse of borrow on subtract
          s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
          h  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
          r  = s[7:0];
          c  = s[8];
          ac = h[4];
          ov = (a[7] == bb[7]) & (r[7] != a[7]);
        end
        `MCS_FN_AND: r = a & b;
        `MCS_FN_OR:  r = a | b;
        `MCS_FN_XOR: r = a ^ b;
        `MCS_FN_CPL: r = ~b;
        `MCS_FN_RR:  r = {b[0], b[7:1]};
        `MCS_FN_RL:  r = {b[6:0], b[7]};
        `MCS_FN_RRC: begin
          r = {fl[`MCS_FL_C], b[7:1]};
          c = b[0];
        end
        `MCS_FN_RLC: begin
          r = {b[6:0], fl[`MCS_FL_C]};
          c = b[7];
        end
        `MCS_FN_INC: r = b + 8'h01;
        `MCS_FN_DEC: r = b - 8'h01;
        `MCS_FN_DAA: begin
          if (b[3:0] > 4'h9 || fl[`MCS_FL_AC]) begin
            adj[3:0] = 4'h6;
          end
          if (b[7:4] > 4'h9 || fl[`MCS_FL_C] || (b[7:4] == 4'h9 && b[3:0] > 4'h9)) begin
            adj[7:4] = 4'h6;
          end
          s = {1'b0, b} + {1'b0, adj};
          r = s[7:0];
          c = fl[`MCS_FL_C] | s[8] | (adj[7:4] != 4'h0);
        end
        default: r = b;
      endcase
      mcs_alu = {ov, ac, (r == 8'h00), c, r};
    end
  endfunction

  reg  [1:0]  phase_reg;
  reg  [11:0] pc_reg;
  reg  [11:0] fetch_addr_reg;
  reg  [15:0] ir_reg;
  reg         ir_valid_reg;
  reg         refetch_reg;
  reg  [7:0]  working_register_reg;
  reg  [3:0]  flag_reg;
  reg  [7:0]  mem_reg [0:15];
  reg  [11:0] stack_reg [0:5];
  reg  [2:0]  stack_level_index_reg;
  reg         run_reg;
  reg         gie_reg;
  reg         ovf_reg;
  reg  [5:0]  irq_flag_reg;
  reg         wr_en;
  reg  [7:0]  wr_data;
  reg         acc_en;
  reg  [7:0]  acc_next;
  reg         fl_en;
  reg  [3:0]  fl_next;
  reg         pc_load;
  reg  [11:0] pc_next;
  reg         push;
  reg         pop;
  reg         gie_set;
  reg  [2:0]  irq_sel;
  reg  [31:0] rd_data;
  reg         rd_err;
  integer     i;
  integer     j;

  wire        t1       = run_reg & (phase_reg == `MCS_PH_T1);
  wire        t4       = run_reg & (phase_reg == `MCS_PH_T4);
  wire [3:0]  op       = ir_reg[15:12];
  wire [3:0]  ma       = ir_reg[3:0];
  wire        exec     = t4 & ir_valid_reg;
  wire [7:0]  mval     = (ma == `MCS_MA_PCL) ? pc_reg[7:0] : mem_reg[ma];
  wire        skipk    = (op == `MCS_OP_SKIP);
  wire [3:0]  alu_fn   = skipk ? (ir_reg[8] ? `MCS_FN_DEC : `MCS_FN_INC) : ir_reg[11:8];
  wire [7:0]  alu_b    = (op == `MCS_OP_ALUI) ? ir_reg[7:0] : mval;
  wire [11:0] alu_out  = mcs_alu(alu_fn, working_register_reg, alu_b, flag_reg);
  wire        stk_full = (stack_level_index_reg == `MCS_STK_DEPTH);
  wire [2:0]  pop_idx  = (stack_level_index_reg == 3'd0) ? 3'd0 : stack_level_index_reg - 3'd1;
  wire        apb_wr   = psel & penable & pwrite;
  wire        irq_go   = t4 & gie_reg & (|irq_flag_reg) & ~stk_full & ~pc_load;

  assign pready = 1'b1;

  // execution decode of the word in the instruction register
  always @* begin
    wr_en    = 1'b0;
    wr_data  = 8'h00;
    acc_en   = 1'b0;
    acc_next = alu_out[7:0];
    fl_en    = 1'b0;
    fl_next  = alu_out[11:8];
    pc_load  = 1'b0;
    pc_next  = pc_reg;
    push     = 1'b0;
    pop      = 1'b0;
    gie_set  = 1'b0;
    if (exec) begin
      case (op)
        `MCS_OP_ALU, `MCS_OP_ALUI: begin
          fl_en   = 1'b1;
          wr_en   = (op == `MCS_OP_ALU) & ir_reg[7];
          wr_data = alu_out[7:0];
          acc_en  = ~wr_en;
        end
        `MCS_OP_STORE: begin
          wr_en   = 1'b1;
          wr_data = working_register_reg;
        end
        `MCS_OP_LOAD: begin
          acc_en   = 1'b1;
          acc_next = mval;
        end
        `MCS_OP_JUMP: begin
          pc_load = 1'b1;
          pc_next = ir_reg[11:0];
        end
        `MCS_OP_CALL: begin
          pc_load = 1'b1;
          pc_next = ir_reg[11:0];
          push    = 1'b1;
        end
        `MCS_OP_RET: begin
          pc_load = 1'b1;
          pc_next = stack_reg[pop_idx];
          pop     = 1'b1;
          gie_set = ir_reg[0];
        end
        `MCS_OP_SKIP: begin
          // the alu result is written back and feeds the skip test only in modes 2 and 3, flags stay
          wr_en   = ir_reg[9];
          wr_data = alu_out[7:0];
          case (ir_reg[9:8])
            2'd0:    pc_load = (mval == 8'h00);
            2'd1:    pc_load = (mval != 8'h00);
            default: pc_load = (alu_out[7:0] == 8'h00);
          endcase
        end
        default: begin
          pc_load = 1'b0;
        end
      endcase
      if (wr_en && ma == `MCS_MA_PCL) begin
        pc_load = 1'b1;
        pc_next = {pc_reg[11:8], wr_data};
      end
    end
  end

  always @* begin
    irq_sel = 3'd0;
    for (j = 5; j >= 0; j = j - 1) begin
      if (irq_flag_reg[j]) begin
        irq_sel = j[2:0];
      end
    end
  end

  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (paddr)
      `MCS_OFS_PCL:  rd_data = {24'h00_0000, pc_reg[7:0]};
      `MCS_OFS_CTRL: rd_data = {30'h0000_0000, gie_reg, run_reg};
      `MCS_OFS_STAT: rd_data = {19'h0_0000, ovf_reg, flag_reg, working_register_reg};
      `MCS_OFS_PC:   rd_data = {20'h0_0000, pc_reg};
      default:       rd_err  = 1'b1;
    endcase
    // pc low byte only writable while halted, so no write races a fetch
    if (pwrite && (paddr == `MCS_OFS_STAT || paddr == `MCS_OFS_PC ||
                   (paddr == `MCS_OFS_PCL && run_reg))) begin
      rd_err = 1'b1;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      phase_reg             <= `MCS_PH_T1;
      instruction_phases    <= 4'h1;
      pc_reg                <= `MCS_RST_VEC;
      fetch_addr_reg        <= `MCS_RST_VEC;
      ir_reg                <= 16'h0000;
      ir_valid_reg          <= 1'b0;
      refetch_reg           <= 1'b0;
      working_register_reg  <= 8'h00;
      flag_reg              <= 4'h0;
      stack_level_index_reg <= 3'd0;
      run_reg               <= `MCS_RUN_RST;
      gie_reg               <= `MCS_GIE_RST;
      ovf_reg               <= 1'b0;
      irq_flag_reg          <= 6'h00;
      irq_ack               <= 1'b0;
      irq_ack_id            <= 3'd0;
      pm_addr               <= 12'h000;
      pm_rd                 <= 1'b0;
      table_addr            <= 12'h000;
      prdata                <= 32'h0000_0000;
      pslverr               <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        mem_reg[i] <= 8'h00;
      end
      for (i = 0; i < 6; i = i + 1) begin
        stack_reg[i] <= 12'h000;
      end
    end else begin
      pm_rd      <= 1'b0;
      irq_ack    <= 1'b0;
      table_addr <= {mem_reg[`MCS_MA_TBH][3:0], mem_reg[`MCS_MA_TBL]};
      // a request arriving while its flag is acknowledged is kept
      irq_flag_reg <= (irq_flag_reg & ~({5'h00, irq_go} << irq_sel)) | irq_req;
      if (run_reg) begin
        phase_reg <= phase_reg + 2'd1;
        instruction_phases <= {instruction_phases[2:0], instruction_phases[3]};
      end
      if (t1) begin
        pm_addr        <= pc_reg;
        pm_rd          <= 1'b1;
        fetch_addr_reg <= pc_reg;
        pc_reg         <= pc_reg + 12'h001;
        refetch_reg    <= 1'b0;
      end
      if (t4) begin
        ir_reg       <= pm_data;
        ir_valid_reg <= ~(pc_load | irq_go | refetch_reg);
      end
      if (pc_load) begin
        pc_reg <= pc_next;
      end
      if (acc_en) begin
        working_register_reg <= acc_next;
      end
      if (fl_en) begin
        flag_reg <= fl_next;
      end
      if (wr_en && ma != `MCS_MA_PCL) begin
        mem_reg[ma] <= wr_data;
      end
      if (push || irq_go) begin
        // overflow overwrites the top entry (level 5, the last pushed); program flow is then lost
        if (stk_full) begin
          stack_reg[`MCS_STK_LAST] <= push ? fetch_addr_reg : pc_reg;
          ovf_reg <= 1'b1;
        end else begin
          stack_reg[stack_level_index_reg] <= push ? fetch_addr_reg : fetch_addr_reg;
          stack_level_index_reg <= stack_level_index_reg + 3'd1;
        end
      end
      if (pop && stack_level_index_reg != 3'd0) begin
        stack_level_index_reg <= stack_level_index_reg - 3'd1;
      end
      if (irq_go) begin
        pc_reg     <= `MCS_VEC_BASE + {7'h00, irq_sel, 2'b00};
        irq_ack    <= 1'b1;
        irq_ack_id <= irq_sel;
      end
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= rd_err;
      end
      if (apb_wr && paddr == `MCS_OFS_PCL && !run_reg) begin
        pc_reg       <= {pc_reg[11:8], pwdata[7:0]};
        ir_valid_reg <= 1'b0;
        // a word prefetched before the halt must not run after resume
        refetch_reg  <= 1'b1;
      end
      if (irq_go) begin
        gie_reg <= 1'b0;
      end else if (gie_set) begin
        gie_reg <= 1'b1;
      end else if (apb_wr && paddr == `MCS_OFS_CTRL) begin
        gie_reg <= pwdata[`MCS_CTRL_GIE];
      end
      if (apb_wr && paddr == `MCS_OFS_CTRL) begin
        run_reg <= pwdata[`MCS_CTRL_RUN];
      end
    end
  end

endmodule

// ==== core/mcs_defs.vh ====
`ifndef MCS_DEFS_VH
`define MCS_DEFS_VH
`define MCS_PC_W       12
`define MCS_STK_DEPTH  3'd6
`define MCS_STK_LAST   3'd5
`define MCS_RST_VEC    12'h000
`define MCS_VEC_BASE   12'h004
`define MCS_PH_T1      2'd0
`define MCS_PH_T4      2'd3
`define MCS_OFS_PCL    12'h000
`define MCS_OFS_CTRL   12'h004
`define MCS_OFS_STAT   12'h008
`define MCS_OFS_PC     12'h00C
`define MCS_CTRL_RUN   0
`define MCS_CTRL_GIE   1
`define MCS_RUN_RST    1'b1
`define MCS_GIE_RST    1'b0
`define MCS_FL_C       0
`define MCS_FL_Z       1
`define MCS_FL_AC      2
`define MCS_FL_OV      3
`define MCS_OP_ALU     4'h0
`define MCS_OP_ALUI    4'h1
`define MCS_OP_STORE   4'h2
`define MCS_OP_LOAD    4'h3
`define MCS_OP_JUMP    4'h4
`define MCS_OP_CALL    4'h5
`define MCS_OP_RET     4'h6
`define MCS_OP_SKIP    4'h7
`define MCS_FN_ADD     4'h0
`define MCS_FN_ADC     4'h1
`define MCS_FN_SUB     4'h2
`define MCS_FN_SBC     4'h3
`define MCS_FN_AND     4'h4
`define MCS_FN_OR      4'h5
`define MCS_FN_XOR     4'h6
`define MCS_FN_CPL     4'h7
`define MCS_FN_RR      4'h8
`define MCS_FN_RRC     4'h9
`define MCS_FN_RL      4'hA
`define MCS_FN_RLC     4'hB
`define MCS_FN_INC     4'hC
`define MCS_FN_DEC     4'hD
`define MCS_FN_DAA     4'hE
`define MCS_MA_TBL     4'hD
`define MCS_MA_TBH     4'hE
`define MCS_MA_PCL     4'hF
`endif

// ==== testbench/mcs_core_sequencer_checker.sv ====
`timescale 1ns/1ps
module mcs_core_sequencer_checker (
  input logic        core_clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  input logic        pslverr,
  input logic        pm_rd,
  input logic [11:0] pm_addr,
  input logic        irq_ack,
  input logic [2:0]  irq_ack_id,
  input logic [3:0]  instruction_phases
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [3:0] ph_rot = {instruction_phases[2:0], instruction_phases[3]};
  wire       setup  = psel && !penable;
  sequence no_fetch3;
    !pm_rd [*3];
  endsequence
  sequence vector_fetch;
    pm_rd && pm_addr == {7'h00, irq_ack_id, 2'b00} + 12'h004;
  endsequence
  phase_onehot_a: assert property ($onehot(instruction_phases))
    else $error("phase not one-hot");
  // stable covers the halted state
  phase_step_a: assert property (
    $stable(instruction_phases) || instruction_phases == $past(ph_rot))
    else $error("phase out of order");
  fetch_t1_a: assert property (pm_rd |-> $past(instruction_phases) == 4'h1)
    else $error("fetch outside first phase");
  fetch_gap_a: assert property (pm_rd |=> no_fetch3)
    else $error("fetches too close");
  addr_hold_a: assert property (!pm_rd |-> $stable(pm_addr))
    else $error("fetch address moved");
  ro_write_a: assert property (
    setup && pwrite && paddr inside {12'h008, 12'h00C} |=> pslverr)
    else $error("read-only write accepted");
  unmapped_a: assert property (
    setup && paddr > 12'h00C |=> pslverr && prdata == 32'h0)
    else $error("unmapped access answered");
  irq_vector_a: assert property (
    irq_ack |-> irq_ack_id < 3'd6 ##[1:5] vector_fetch)
    else $error("vector not fetched");
  irq_pulse_a: assert property (irq_ack |=> !irq_ack [*3])
    else $error("acknowledge too long");
endmodule
bind mcs_core_sequencer mcs_core_sequencer_checker chk (.core_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .prdata, .pslverr, .pm_rd, .pm_addr, .irq_ack, .irq_ack_id,
  .instruction_phases);

// ==== testbench/mcs_pmem_model.sv ====
`timescale 1ns/1ps
module mcs_pmem_model #(
  parameter LAT = 1
) (
  input  logic        core_clk,
  input  logic        pm_rd,
  input  logic [11:0] pm_addr,
  output logic [15:0] pm_data
);
  logic [15:0] mem [0:4095];
  logic [11:0] adr_reg = 12'h000;
  int          wait_reg = 0;
  // word at the latched pc, sixteen bits
  always @(posedge core_clk) begin
    if (pm_rd === 1'b1) begin
      adr_reg <= pm_addr;
      wait_reg <= LAT;
    end else if (wait_reg > 0) begin
      wait_reg <= wait_reg - 1;
    end
  end
  // inverted word until ready, so an early sample is caught
  assign pm_data = (wait_reg == 0) ? mem[adr_reg] : ~mem[adr_reg];
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        core_clk = 1'b0, rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [5:0]  irq_req = 6'h00;
  logic        pready, pslverr, pm_rd, irq_ack, er;
  logic [11:0] pm_addr, table_addr, fa[$];
  logic [15:0] pm_data;
  logic [2:0]  irq_ack_id;
  logic [3:0]  instruction_phases;
  int          ft[$], cyc = 0, bad_count = 0, compares = 0;
  always #25 core_clk = ~core_clk;
  mcs_core_sequencer dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pm_addr, .pm_rd, .pm_data, .irq_req, .irq_ack,
    .irq_ack_id, .instruction_phases, .table_addr);
  mcs_pmem_model #(.LAT(1)) pm (.core_clk, .pm_rd, .pm_addr, .pm_data);
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (pm_rd === 1'b1) begin
      fa.push_back(pm_addr);
      ft.push_back(cyc);
    end
  end
  task print_verdict;
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task hang(input string what);
    bad_count++;
    $display("unexpected at %0t: %s timed out", $time, what);
    print_verdict();
  endtask
  task wait_fetch(input int n);
    for (int k = 0; k < 400 && fa.size() < n; k++) @(posedge core_clk);
    if (fa.size() < n) hang("fetch");
  endtask
  task seq(input logic [11:0] e[$]);
    wait_fetch(e.size());
    foreach (e[i]) chk(fa[i], e[i], "fetch address");
  endtask
  // zero wait states promised, but the master still polls pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) hang("apb");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset mid-run on purpose, with a fresh program of nops
  task boot(input logic [15:0] w[$]);
    for (int i = 0; i < 4096; i++) pm.mem[i] = 16'hF000;
    foreach (w[i]) pm.mem[i] = w[i];
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    fa.delete();
    ft.delete();
    rst <= 1'b0;
  endtask
  task s_alu;
    boot('{16'h1005, 16'h1203, 16'h200D});
    seq('{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005});
    for (int i = 1; i < 6; i++) chk(ft[i] - ft[i-1], 4, "fetch spacing");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[9:0], 10'h102, "result and flags");
    chk(table_addr[7:0], 8'h02, "table pointer");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h1, "control after reset");
  endtask
  task s_branch;
    boot('{16'h5010, 16'h1001, 16'h4100, 16'h1020});
    pm.mem[16] = 16'h6000;
    pm.mem[17] = 16'h1010;
    seq('{12'h000, 12'h001, 12'h010, 12'h011, 12'h001, 12'h002, 12'h003, 12'h100});
    repeat (12) @(posedge core_clk);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[7:0], 8'h01, "discarded words");
  endtask
  task s_skip;
    boot('{16'h1000, 16'h2003, 16'h7003, 16'h1077, 16'h1001});
    seq('{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005});
    repeat (8) @(posedge core_clk);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[7:0], 8'h01, "skipped word");
  endtask
  task s_pcl;
    boot('{16'h4300});
    wait_fetch(4);
    apb(1'b1, 12'h000, 32'h40);
    chk(er, 1'b1, "low write while running");
    apb(1'b1, 12'h00C, 32'h0);
    chk(er, 1'b1, "high write");
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h40);
    chk(er, 1'b0, "low write halted");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h40, "low readback");
    fa.delete();
    apb(1'b1, 12'h004, 32'h1);
    seq('{12'h340, 12'h341});
  endtask
  task s_irq;
    logic seen;
    seen = 1'b0;
    boot('{16'h5001, 16'h5002, 16'h5003, 16'h5004, 16'h5005, 16'h5006, 16'hF000,
      16'hF000, 16'h6000});
    apb(1'b1, 12'h004, 32'h3);
    wait_fetch(14);
    irq_req <= 6'h04;
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      irq_req <= 6'h00;
      seen = seen | irq_ack;
    end
    chk(seen, 1'b0, "ack with stack full");
    for (int i = 0; i < 60 && irq_ack !== 1'b1; i++) @(posedge core_clk);
    if (irq_ack !== 1'b1) hang("ack");
    chk(irq_ack_id, 3'd2, "ack source");
    // vector fetch only after the return has freed a level
    seq('{12'h000, 12'h001, 12'h001, 12'h002, 12'h002, 12'h003,
      12'h003, 12'h004, 12'h004, 12'h005, 12'h005, 12'h006,
      12'h006, 12'h007, 12'h008, 12'h009, 12'h006, 12'h00C});
  endtask
  task s_ovf;
    boot('{16'h5001, 16'h5002, 16'h5003, 16'h5004, 16'h5005, 16'h5006, 16'h5007});
    seq('{12'h000, 12'h001, 12'h001, 12'h002, 12'h002, 12'h003, 12'h003, 12'h004,
      12'h004, 12'h005, 12'h005, 12'h006, 12'h006, 12'h007, 12'h007});
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[12], 1'b1, "overflow flag");
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    s_alu();
    s_branch();
    s_skip();
    s_pcl();
    s_irq();
    s_ovf();
    print_verdict();
  end
endmodule
